// ===== hdl/coproc_defines.svh
`ifndef COPROC_DEFINES_SVH
`define COPROC_DEFINES_SVH

// ----------------------------------------
// Register specifiers
// ----------------------------------------
`define NUM_REGS 55
`define NUM_TRACKED 48
`define SPEC_LAST_REG 6'h36
`define SPEC_LAST_ALU_DEST 6'h2f
`define SPEC_CONST_ZERO 6'h34
`define SPEC_CONST_HALF 6'h35
`define SPEC_CONST_ONE 6'h36

// ----------------------------------------
// Constant operands in G format
// ----------------------------------------
`define G_ZERO 64'h0000_0000_0000_0000
`define G_HALF 64'h4000_0000_0000_0000
`define G_ONE 64'h4010_0000_0000_0000

// ----------------------------------------
// Major opcodes
// ----------------------------------------
`define OPC_TO_FPU 4'h4
`define OPC_FROM_FPU 4'h5
`define OPC_ALU 4'h6
`define OPC_STORE 4'ha
`define OPC_LOAD 4'hb

// ----------------------------------------
// Unit and function codes
// ----------------------------------------
`define UNIT_ADDER 2'h1
`define UNIT_MULT 2'h2
`define UNIT_RECIP 2'h3
`define FN_0 2'h0
`define FN_1 2'h1
`define FN_2 2'h2
`define FN_3 2'h3

// ----------------------------------------
// Software registers
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ELEM_COUNT 8'h08
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'b1

`endif

// ===== hdl/coproc_pkg.sv
package coproc_pkg;
    typedef enum logic [1:0] {
        LST_LOAD = 2'b00,
        LST_STORE = 2'b01,
        LST_IN = 2'b10,
        LST_OUT = 2'b11
    } lst_kind_t;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_ADD = 4'b0001,
        OP_SUB = 4'b0010,
        OP_FLOAT = 4'b0011,
        OP_TRUNC = 4'b0100,
        OP_FMUL = 4'b0101,
        OP_IMUL = 4'b0110,
        OP_ITER = 4'b0111,
        OP_RECIP = 4'b1000
    } alu_op_t;

    typedef struct packed {
        logic [3:0] opcode;
        logic [5:0] dest;
        logic [5:0] src_a;
        logic [5:0] src_b;
        logic [1:0] unit;
        logic [1:0] func;
        logic [3:0] len_m1;
        logic hold_a;
        logic hold_b;
    } alu_instr_t;

    typedef struct packed {
        logic valid;
        lst_kind_t kind;
        logic [5:0] spec;
    } lst_t;

    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [5:0] dest;
        logic write_en;
        logic [63:0] op_a;
        logic [63:0] op_b;
    } issue_t;

    typedef struct packed {
        logic valid;
        logic [5:0] spec;
        logic [63:0] data;
    } result_t;
endpackage

// ===== hdl/operand_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "coproc_defines.svh"

module operand_regfile #(
    parameter int NUM_REGS = `NUM_REGS,
    parameter int NUM_RD = 2,
    parameter int NUM_WR = 1
) (
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic [NUM_WR-1:0] wr_en_i,
    input wire logic [NUM_WR-1:0] wr_upper_i,
    input wire logic [NUM_WR-1:0][5:0] wr_idx_i,
    input wire logic [NUM_WR-1:0][63:0] wr_data_i,
    input wire logic [NUM_RD-1:0][5:0] rd_idx_i,
    output logic [NUM_RD-1:0][63:0] rd_data_o
);
    logic [63:0] regs [NUM_REGS];

    // Higher write ports win on a clash; upper-only writes keep the low half
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            for (int w = 0; w < NUM_WR; w++) begin
                if (wr_en_i[w] && int'(wr_idx_i[w]) < NUM_REGS) begin
                    regs[wr_idx_i[w]][63:32] <= wr_data_i[w][63:32];
                    if (!wr_upper_i[w]) begin
                        regs[wr_idx_i[w]][31:0] <= wr_data_i[w][31:0];
                    end
                end
            end
        end
    end

    for (genvar r = 0; r < NUM_RD; r++) begin : g_rd
        assign rd_data_o[r] = (int'(rd_idx_i[r]) < NUM_REGS) ? regs[rd_idx_i[r]] : 64'h0;
    end
endmodule
`default_nettype wire

// ===== hdl/dest_scoreboard.sv
`timescale 1ns/1ps
`default_nettype none
`include "coproc_defines.svh"

module dest_scoreboard #(
    parameter int NUM_TRACKED = `NUM_TRACKED
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic set_i,
    input wire logic [5:0] set_idx_i,
    input wire logic clr_i,
    input wire logic [5:0] clr_idx_i,
    output logic [NUM_TRACKED-1:0] pending_o
);
    logic [NUM_TRACKED-1:0] next_pending;

    // A reservation made in the same cycle as a retirement survives
    for (genvar i = 0; i < NUM_TRACKED; i++) begin : g_bit
        always_comb begin
            next_pending[i] = pending_o[i];
            if (clr_i && clr_idx_i == 6'(i)) begin
                next_pending[i] = 1'b0;
            end
            if (set_i && set_idx_i == 6'(i)) begin
                next_pending[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pending_o <= '0;
        end else if (ce_i) begin
            pending_o <= next_pending;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/issue_port.sv
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "coproc_defines.svh"

// Overview of operation
// - Sources 52-54 read zero, half, one
// - Constant destination writes nothing, still interlocked
// - Constant NOP waits until vector register empties
// - Reserve each written element destination (0-47, decoded op) at its issue
// - Transfers are aligned 64-bit doublewords
// - Load writes whole doubleword to register
// - Store drives full register onto data bus
// - Pending source holds writeback advance low
// - Inbound fills upper half one stage later
// - Outbound drives upper half one stage earlier
// - Accept arithmetic only for destinations 0-47 and 52-54
// - Every arithmetic instruction is a vector
// - Clear at zero length, else step and reissue
// - Hold bits freeze their source specifier
// - Unit field selects adder, multiplier, reciprocal
// - Adder codes: add, subtract, float, trunc
// - Multiplier and reciprocal function decoding
// - Claim by destination or source specifier
module issue_port (
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic LST_VALID_I,
    input wire logic [3:0] LST_OPCODE_I,
    input wire logic [5:0] LST_SPEC_I,
    input wire logic ALU_VALID_I,
    input wire coproc_pkg::alu_instr_t ALU_INSTR_I,
    input wire logic [63:0] DATA_I,
    output logic [63:0] DATA_O,
    output logic DATA_OE_N_O,
    output logic WRITEBACK_ADVANCE_O,
    input wire logic ISSUE_READY_I,
    output coproc_pkg::issue_t ISSUE_O,
    input wire coproc_pkg::result_t RESULT_I
);
    import coproc_pkg::*;

    lst_t lst_mem, lst_wb, lst_x, next_lst_mem, next_lst_wb, next_lst_x;
    lst_kind_t in_kind;
    logic in_claim, stall_front, stall_back, stall, stall_alu;
    logic [63:0] data_out, next_data_out;
    logic data_drive, next_data_drive;
    alu_instr_t ir, next_ir;
    logic ir_valid, next_ir_valid, alu_claim, can_issue, issue_we;
    logic ctrl_en, next_ctrl_en;
    issue_t issue_q, next_issue;
    alu_op_t ir_op;
    logic [`NUM_TRACKED-1:0] pending;
    logic [3:0][5:0] rd_idx;
    logic [3:0][63:0] rd_data;
    logic [2:0] wr_en, wr_upper;
    logic [2:0][5:0] wr_idx;
    logic [2:0][63:0] wr_data;
    logic [7:0] ahb_addr, next_ahb_addr;
    logic ahb_wr, next_ahb_wr, ahb_sel;
    logic [31:0] hrdata, next_hrdata, elem_count, next_elem_count;

    function automatic logic busy(input logic [5:0] spec, input logic [`NUM_TRACKED-1:0] pend);
        busy = (int'(spec) < `NUM_TRACKED) && pend[spec];
    endfunction

    function automatic logic [63:0] operand(input logic [5:0] spec, input logic [63:0] stored);
        unique case (spec)
            `SPEC_CONST_ZERO: operand = `G_ZERO;
            `SPEC_CONST_HALF: operand = `G_HALF;
            `SPEC_CONST_ONE: operand = `G_ONE;
            default: operand = stored;
        endcase
    endfunction

    // ----------------------------------------
    // Storage and interlocks
    // ----------------------------------------
    assign rd_idx = {LST_SPEC_I, lst_mem.spec, ir.src_b, ir.src_a};
    assign wr_en[0] = RESULT_I.valid;
    assign wr_upper[0] = 1'b0;
    assign wr_idx[0] = RESULT_I.spec;
    assign wr_data[0] = RESULT_I.data;
    assign wr_en[1] = lst_wb.valid && lst_wb.kind == LST_LOAD && !stall_back;
    assign wr_upper[1] = 1'b0;
    assign wr_idx[1] = lst_wb.spec;
    assign wr_data[1] = DATA_I;
    assign wr_en[2] = lst_x.valid && lst_x.kind == LST_IN && !stall_back;
    assign wr_upper[2] = 1'b1;
    assign wr_idx[2] = lst_x.spec;
    assign wr_data[2] = DATA_I;

    operand_regfile #(.NUM_REGS(`NUM_REGS), .NUM_RD(4), .NUM_WR(3)) u_regs (
        .clk_i(SYS_CLK_I),
        .ce_i(CE_I),
        .wr_en_i(wr_en),
        .wr_upper_i(wr_upper),
        .wr_idx_i(wr_idx),
        .wr_data_i(wr_data),
        .rd_idx_i(rd_idx),
        .rd_data_o(rd_data)
    );

    dest_scoreboard #(.NUM_TRACKED(`NUM_TRACKED)) u_board (
        .clk_i(SYS_CLK_I),
        .rstn_i(RESETN_I),
        .ce_i(CE_I),
        .set_i(can_issue && issue_we),
        .set_idx_i(ir.dest),
        .clr_i(RESULT_I.valid),
        .clr_idx_i(RESULT_I.spec),
        .pending_o(pending)
    );

    // ----------------------------------------
    // Load, store and transfer pipeline
    // ----------------------------------------
    always_comb begin
        in_kind = LST_LOAD;
        in_claim = 1'b0;
        unique case (LST_OPCODE_I)
            `OPC_LOAD: begin in_kind = LST_LOAD; in_claim = 1'b1; end
            `OPC_STORE: begin in_kind = LST_STORE; in_claim = 1'b1; end
            `OPC_TO_FPU: begin in_kind = LST_IN; in_claim = 1'b1; end
            `OPC_FROM_FPU: begin in_kind = LST_OUT; in_claim = 1'b1; end
            default: in_claim = 1'b0;
        endcase
        in_claim = in_claim && LST_VALID_I && LST_SPEC_I <= `SPEC_LAST_REG;
    end

    // The front stall only bubbles the MEM slot, so a store ahead can still drain
    assign stall_front = in_claim && in_kind == LST_OUT && (busy(LST_SPEC_I, pending)
        || (lst_mem.valid && lst_mem.kind == LST_STORE));
    assign stall_back = lst_mem.valid && lst_mem.kind == LST_STORE
        && busy(lst_mem.spec, pending);
    assign stall_alu = alu_claim && ir_valid;
    assign stall = stall_front || stall_back || stall_alu;
    assign WRITEBACK_ADVANCE_O = !stall;

    always_comb begin
        next_lst_mem = lst_mem;
        next_lst_wb = lst_wb;
        next_lst_x = lst_x;
        next_data_out = data_out;
        next_data_drive = data_drive;
        if (!stall_back) begin
            next_lst_mem = '{valid: in_claim && !stall, kind: in_kind, spec: LST_SPEC_I};
            next_lst_wb = lst_mem;
            next_lst_x = lst_wb;
            next_data_drive = 1'b0;
            if (lst_mem.valid && lst_mem.kind == LST_STORE) begin
                next_data_out = rd_data[2];
                next_data_drive = 1'b1;
            end else if (in_claim && in_kind == LST_OUT && !stall) begin
                next_data_out = {rd_data[3][63:32], 32'h0};
                next_data_drive = 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            lst_mem <= '0;
            lst_wb <= '0;
            lst_x <= '0;
            data_out <= 64'h0;
            data_drive <= 1'b0;
        end else if (CE_I) begin
            lst_mem <= next_lst_mem;
            lst_wb <= next_lst_wb;
            lst_x <= next_lst_x;
            data_out <= next_data_out;
            data_drive <= next_data_drive;
        end
    end

    assign DATA_O = data_out;
    assign DATA_OE_N_O = !data_drive;

    // ----------------------------------------
    // Arithmetic instruction register
    // ----------------------------------------
    assign alu_claim = ALU_VALID_I && ALU_INSTR_I.opcode == `OPC_ALU
        && (ALU_INSTR_I.dest <= `SPEC_LAST_ALU_DEST
        || ALU_INSTR_I.dest >= `SPEC_CONST_ZERO && ALU_INSTR_I.dest <= `SPEC_CONST_ONE);

    always_comb begin
        unique case ({ir.unit, ir.func})
            {`UNIT_ADDER, `FN_0}: ir_op = OP_ADD;
            {`UNIT_ADDER, `FN_1}: ir_op = OP_SUB;
            {`UNIT_ADDER, `FN_2}: ir_op = OP_FLOAT;
            {`UNIT_ADDER, `FN_3}: ir_op = OP_TRUNC;
            {`UNIT_MULT, `FN_0}: ir_op = OP_FMUL;
            {`UNIT_MULT, `FN_1}: ir_op = OP_IMUL;
            {`UNIT_MULT, `FN_2}: ir_op = OP_ITER;
            {`UNIT_RECIP, `FN_0}: ir_op = OP_RECIP;
            default: ir_op = OP_NONE;
        endcase
    end

    // Constant targets and reserved encodings still pass every interlock
    assign issue_we = ir.dest <= `SPEC_LAST_ALU_DEST && ir_op != OP_NONE;
    assign can_issue = ir_valid && ctrl_en && ISSUE_READY_I && !busy(ir.src_a, pending)
        && !busy(ir.src_b, pending) && !busy(ir.dest, pending);

    always_comb begin
        next_ir = ir;
        next_ir_valid = ir_valid;
        next_issue = issue_q;
        next_issue.valid = 1'b0;
        if (can_issue) begin
            next_issue = '{valid: 1'b1, op: ir_op, dest: ir.dest, write_en: issue_we,
                op_a: operand(ir.src_a, rd_data[0]), op_b: operand(ir.src_b, rd_data[1])};
            if (ir.len_m1 == 4'h0) begin
                next_ir_valid = 1'b0;
            end else begin
                next_ir.len_m1 = ir.len_m1 - 4'h1;
                next_ir.dest = ir.dest + 6'h1;
                next_ir.src_a = ir.hold_a ? ir.src_a : ir.src_a + 6'h1;
                next_ir.src_b = ir.hold_b ? ir.src_b : ir.src_b + 6'h1;
            end
        end
        if (alu_claim && !stall) begin
            next_ir = ALU_INSTR_I;
            next_ir_valid = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            ir <= '0;
            ir_valid <= 1'b0;
            issue_q <= '0;
        end else if (CE_I) begin
            ir <= next_ir;
            ir_valid <= next_ir_valid;
            issue_q <= next_issue;
        end
    end

    assign ISSUE_O = issue_q;

    // ----------------------------------------
    // AHB-Lite register slave
    // ----------------------------------------
    assign ahb_sel = HSEL_I && HTRANS_I[1] && HREADY_I;

    // Zero wait states; a read just behind a write to the same word sees the old value
    always_comb begin
        next_ahb_wr = ahb_sel && HWRITE_I;
        next_ahb_addr = ahb_sel ? HADDR_I[7:0] : ahb_addr;
        next_hrdata = hrdata;
        next_ctrl_en = ctrl_en;
        next_elem_count = elem_count;
        if (ahb_sel && !HWRITE_I) begin
            unique case (HADDR_I[7:0])
                `REG_CTRL: next_hrdata = {31'h0, ctrl_en};
                `REG_STATUS: next_hrdata = {26'h0, stall, ir.len_m1, ir_valid};
                `REG_ELEM_COUNT: next_hrdata = elem_count;
                default: next_hrdata = 32'h0;
            endcase
        end
        if (ahb_wr && ahb_addr == `REG_CTRL) begin
            next_ctrl_en = HWDATA_I[`CTRL_ENABLE_BIT];
        end
        if (ahb_wr && ahb_addr == `REG_ELEM_COUNT) begin
            next_elem_count = 32'h0;
        end
        if (can_issue) begin
            next_elem_count = next_elem_count + 32'h1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            ahb_wr <= 1'b0;
            ahb_addr <= 8'h0;
            hrdata <= 32'h0;
            ctrl_en <= `CTRL_RESET;
            elem_count <= 32'h0;
        end else if (CE_I) begin
            ahb_wr <= next_ahb_wr;
            ahb_addr <= next_ahb_addr;
            hrdata <= next_hrdata;
            ctrl_en <= next_ctrl_en;
            elem_count <= next_elem_count;
        end
    end

    assign HRDATA_O = hrdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking dclk @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);

    AST_CONST_HALF: assert property (CE_I && can_issue && ir.src_a == `SPEC_CONST_HALF
        |=> ISSUE_O.valid && ISSUE_O.op_a == `G_HALF) else $error("half constant not supplied");
    AST_CONST_DEST: assert property (CE_I && can_issue && ir.dest >= `SPEC_CONST_ZERO
        |=> ISSUE_O.valid && !ISSUE_O.write_en) else $error("constant target was written");
    AST_NOP_WAIT: assert property (alu_claim && ir_valid
        |-> !WRITEBACK_ADVANCE_O) else $error("intake not stalled behind busy register");
    AST_RESERVE: assert property (CE_I && can_issue && issue_we && !RESULT_I.valid
        |=> pending[$past(ir.dest)]) else $error("element destination not reserved");
    AST_STORE_DATA: assert property (CE_I && lst_mem.valid && lst_mem.kind == LST_STORE
        && !stall_back |=> !DATA_OE_N_O && DATA_O == $past(rd_data[2]))
        else $error("store data not driven");
    AST_STORE_STALL: assert property (lst_mem.valid && lst_mem.kind == LST_STORE
        && busy(lst_mem.spec, pending) |-> !WRITEBACK_ADVANCE_O) else $error("store not held");
    AST_OUT_UPPER: assert property (CE_I && in_claim && in_kind == LST_OUT && !stall
        |=> !DATA_OE_N_O && DATA_O[63:32] == $past(rd_data[3][63:32]))
        else $error("outbound word not driven");
    AST_REJECT_DEST: assert property (CE_I && !ir_valid && ALU_VALID_I
        && ALU_INSTR_I.dest > `SPEC_LAST_ALU_DEST && ALU_INSTR_I.dest < `SPEC_CONST_ZERO
        |=> !ir_valid) else $error("out-of-range destination accepted");
    AST_VECTOR_STEP: assert property (CE_I && can_issue && ir.len_m1 != 4'h0 && !alu_claim
        |=> ir_valid && ir.len_m1 == 4'($past(ir.len_m1) - 4'h1)
        && ir.dest == 6'($past(ir.dest) + 6'h1)) else $error("vector step wrong");
    AST_HOLD_A: assert property (CE_I && can_issue && ir.hold_a && ir.len_m1 != 4'h0
        |=> ir.src_a == $past(ir.src_a)) else $error("held source moved");
    AST_RESERVED_OP: assert property (CE_I && can_issue && ir_op == OP_NONE
        |=> ISSUE_O.valid && !ISSUE_O.write_en) else $error("reserved op writes");

    COV_VECTOR: cover property (can_issue && ir.len_m1 != 4'h0 ##1 can_issue);
    COV_STORE_STALL: cover property (stall_back ##[1:20] !stall_back);
    COV_NOP_STALL: cover property (stall_alu && ALU_INSTR_I.dest == `SPEC_CONST_ZERO);
    COV_OUTBOUND: cover property (in_claim && in_kind == LST_OUT && !stall);
endmodule
`default_nettype wire

// ===== tb/cpu_side_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "coproc_defines.svh"

module cpu_side_model (
    input wire logic clk_i,
    input wire logic valid_i,
    input wire logic [3:0] opcode_i,
    input wire logic advance_i,
    input wire logic [63:0] mem_word_i,
    input wire logic [31:0] cpu_word_i,
    output logic [63:0] data_o
);
    logic [3:0] stage [1:3] = '{default: 4'h0};
    logic [63:0] last = 64'h0;

    // ----------------------------------------
    // Pipeline tracking of taken transfers
    // ----------------------------------------
    always @(posedge clk_i) begin
        stage[1] <= (valid_i && advance_i) ? opcode_i : 4'h0;
        stage[2] <= stage[1];
        stage[3] <= stage[2];
        last <= data_o;
    end

    // Memory only answers loads; a released bus never shows the old value
    always_comb begin
        data_o = ~last;
        if (stage[2] == `OPC_LOAD)
            data_o = mem_word_i;
        if (stage[3] == `OPC_TO_FPU)
            data_o = {cpu_word_i, ~last[31:0]};
    end
endmodule
`default_nettype wire

// ===== tb/tb_issue_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "coproc_defines.svh"

module tb_issue_port;
    import coproc_pkg::*;
    logic SYS_CLK_I = 0, RESETN_I = 0, HSEL_I, HWRITE_I, LST_VALID_I, ALU_VALID_I, hold_res;
    logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, cpu_word;
    logic [1:0] HTRANS_I;
    logic [3:0] LST_OPCODE_I;
    logic [5:0] LST_SPEC_I;
    logic [63:0] DATA_O, mem_word, regs [64];
    wire logic [63:0] DATA_I;
    logic HREADYOUT_O, HRESP_O, DATA_OE_N_O, WRITEBACK_ADVANCE_O;
    alu_instr_t ALU_INSTR_I;
    issue_t ISSUE_O;
    result_t RESULT_I = '0, r;
    issue_t iq [$];
    result_t rq [$];
    int error_cnt = 0, tests_run = 0;
    alu_op_t tbl [16] = '{OP_NONE, OP_NONE, OP_NONE, OP_NONE, OP_ADD, OP_SUB, OP_FLOAT,
        OP_TRUNC, OP_FMUL, OP_IMUL, OP_ITER, OP_NONE, OP_RECIP, OP_NONE, OP_NONE, OP_NONE};

    always #5 SYS_CLK_I = ~SYS_CLK_I;

    issue_port i_issue_port (.SYS_CLK_I, .RESETN_I, .CE_I(1'b1), .HSEL_I, .HADDR_I, .HTRANS_I,
        .HWRITE_I, .HSIZE_I(3'h2), .HWDATA_I, .HREADY_I(HREADYOUT_O), .HRDATA_O, .HREADYOUT_O,
        .HRESP_O, .LST_VALID_I, .LST_OPCODE_I, .LST_SPEC_I, .ALU_VALID_I, .ALU_INSTR_I,
        .DATA_I, .DATA_O, .DATA_OE_N_O, .WRITEBACK_ADVANCE_O, .ISSUE_READY_I(1'b1), .ISSUE_O,
        .RESULT_I);
    cpu_side_model i_cpu_side_model (.clk_i(SYS_CLK_I), .valid_i(LST_VALID_I),
        .opcode_i(LST_OPCODE_I), .advance_i(WRITEBACK_ADVANCE_O), .mem_word_i(mem_word),
        .cpu_word_i(cpu_word), .data_o(DATA_I));

    // ----------------------------------------
    // Datapath stand-in: results can be withheld to keep a register busy
    // ----------------------------------------
    always @(posedge SYS_CLK_I) begin
        RESULT_I <= '0;
        if (!hold_res && rq.size() > 0) begin
            r = rq.pop_front();
            regs[r.spec] = r.data;
            RESULT_I <= r;
        end
        if (ISSUE_O.valid === 1'b1) begin
            iq.push_back(ISSUE_O);
            if (ISSUE_O.write_en === 1'b1)
                rq.push_back({1'b1, ISSUE_O.dest, $urandom, $urandom});
        end
    end

    task automatic check(string what, logic [64:0] seen, logic [64:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge SYS_CLK_I);
    endtask

    task automatic wait_on(bit bus);
        int k;
        for (k = 0; k < 99; k++) begin
            @(posedge SYS_CLK_I);
            if ((bus ? HREADYOUT_O : WRITEBACK_ADVANCE_O) === 1'b1)
                break;
        end
        if (k == 99) begin
            error_cnt++;
            give_verdict();
        end
    endtask

    task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
        HSEL_I <= 1'b1;
        HADDR_I <= a;
        HWRITE_I <= wr;
        HTRANS_I <= 2'h2;
        wait_on(1);
        HSEL_I <= 1'b0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= wd;
        wait_on(1);
        rd = HRDATA_O;
        check("resp", HRESP_O, 0);
    endtask

    task automatic lst(logic [3:0] opc, logic [5:0] s, logic [63:0] w);
        mem_word <= w;
        cpu_word <= w[63:32];
        LST_VALID_I <= 1'b1;
        LST_OPCODE_I <= opc;
        LST_SPEC_I <= s;
        wait_on(0);
        LST_VALID_I <= 1'b0;
        #1;
        if (opc == `OPC_FROM_FPU)
            check("outbound", {DATA_OE_N_O, DATA_O[63:32]}, {1'b0, regs[s][63:32]});
        wait_on(0);
        #1;
        if (opc == `OPC_STORE)
            check("store", {DATA_OE_N_O, DATA_O}, {1'b0, regs[s]});
        if (opc == `OPC_LOAD)
            regs[s] = w;
        if (opc == `OPC_TO_FPU)
            regs[s][63:32] = w[63:32];
        tick(3);
    endtask

    function automatic logic [63:0] src(logic [5:0] s);
        if (s == `SPEC_CONST_ZERO)
            return `G_ZERO;
        if (s == `SPEC_CONST_HALF)
            return `G_HALF;
        if (s == `SPEC_CONST_ONE)
            return `G_ONE;
        return regs[s];
    endfunction

    function automatic alu_instr_t rnd(int u, int f, int len);
        return '{`OPC_ALU, 6'(24 + $urandom_range(19)), 6'($urandom_range(19)),
            6'($urandom_range(19)), 2'(u), 2'(f), 4'(len), 1'($urandom), 1'($urandom)};
    endfunction

    task automatic go(alu_instr_t ins);
        ALU_VALID_I <= 1'b1;
        ALU_INSTR_I <= ins;
        wait_on(0);
        ALU_VALID_I <= 1'b0;
    endtask

    task automatic alu(alu_instr_t ins, int n);
        logic [63:0] ea [16], eb [16];
        alu_op_t op;
        int k;
        op = tbl[{ins.unit, ins.func}];
        for (k = 0; k < 16; k++) begin
            ea[k] = src(ins.src_a + (ins.hold_a ? 6'h0 : 6'(k)));
            eb[k] = src(ins.src_b + (ins.hold_b ? 6'h0 : 6'(k)));
        end
        iq.delete();
        go(ins);
        for (k = 0; k < 99 && iq.size() < n; k++)
            tick(1);
        tick(4);
        check("elements", iq.size(), n);
        for (k = 0; k < iq.size() && k < n; k++) begin
            check("dest", iq[k].dest, ins.dest + 6'(k));
            check("op", iq[k].op, op);
            check("wen", iq[k].write_en, ins.dest < 48 && op != OP_NONE);
            check("op_a", iq[k].op_a, ea[k]);
            check("op_b", iq[k].op_b, eb[k]);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        alu_instr_t ins;
        logic [31:0] rd;
        int k, s;
        {HSEL_I, HWRITE_I, HTRANS_I, HADDR_I, HWDATA_I, LST_VALID_I, LST_OPCODE_I} = '0;
        {LST_SPEC_I, ALU_VALID_I, ALU_INSTR_I, mem_word, cpu_word, hold_res} = '0;
        void'($urandom(52218));
        tick(20);
        RESETN_I <= 1'b1;
        tick(1);
        #1;
        check("reset", {ISSUE_O.valid, DATA_OE_N_O, WRITEBACK_ADVANCE_O}, 3'b011);
        tick(1);
        ahb(0, `REG_CTRL, 0, rd);
        check("ctrl", rd, 1);
        ahb(1, `REG_CTRL, 0, rd);
        ahb(0, `REG_CTRL, 0, rd);
        check("ctrl off", rd, 0);
        ahb(1, `REG_CTRL, 1, rd);
        ahb(0, 32'h40, 0, rd);
        check("unmapped", rd, 0);
        for (k = 0; k < 48; k++)
            lst(`OPC_LOAD, 6'(k), {$urandom, $urandom});
        for (k = 0; k < 8; k++) begin
            s = $urandom_range(47);
            lst(`OPC_STORE, 6'(s), 0);
            lst(`OPC_TO_FPU, 6'(s), {$urandom, 32'h0});
            lst(`OPC_FROM_FPU, 6'(s), 0);
            lst(`OPC_STORE, 6'(s), 0);
        end
        for (k = 0; k < 16; k++)
            alu(rnd(k >> 2, k, 0), 1);
        for (k = 0; k < 6; k++) begin
            ins = rnd(1, 0, $urandom_range(3));
            alu(ins, ins.len_m1 + 1);
        end
        ins = rnd(1, 2, 0);
        ins.src_b = ins.src_a;
        alu(ins, 1);
        for (k = 52; k < 55; k++) begin
            ins = rnd(1, 0, 1);
            ins.src_a = 6'(k);
            ins.hold_a = 1'b1;
            alu(ins, 2);
        end
        ins.dest = `SPEC_CONST_ZERO;
        alu(ins, 2);
        ins.dest = 6'h30;
        alu(ins, 0);
        ins = rnd(1, 0, 1);
        ins.dest = 6'h1e;
        ins.src_a = 6'h1f;
        ins.hold_a = 1'b1;
        alu(ins, 2);
        iq.delete();
        go('{`OPC_ALU, 6'h18, 6'h34, 6'h36, 2'h1, 2'h0, 4'hf, 1'b1, 1'b1});
        tick(1);
        go('{`OPC_ALU, 6'h34, 6'h35, 6'h36, 2'h1, 2'h0, 4'h0, 1'b0, 1'b0});
        #1;
        check("nop waits", iq.size() >= 16, 1);
        tick(5);
        for (k = 0; k < 2; k++) begin
            hold_res <= 1'b1;
            ins = rnd(2, 0, 0);
            alu(ins, 1);
            fork
                lst(k ? `OPC_STORE : `OPC_FROM_FPU, ins.dest, 0);
                begin
                    tick(4);
                    #1;
                    check("advance", WRITEBACK_ADVANCE_O, 0);
                    hold_res = 1'b0;
                end
            join
        end
        ahb(1, `REG_ELEM_COUNT, 0, rd);
        alu(rnd(2, 1, 3), 4);
        ahb(0, `REG_ELEM_COUNT, 0, rd);
        check("count", rd, 4);
        give_verdict();
    end
endmodule
`default_nettype wire
